/* File: src/adc_ctrl_pkg.sv */
// Types shared by the converter control block and its sequencer.
// Assumes the includer also pulls in adc_ctrl_regs.svh for the numbers.
package adc_ctrl_pkg;
   typedef enum {
      SEQ_IDLE,
      SEQ_SAMPLE,
      SEQ_DONE
   } seq_state_t;
   typedef logic [9:0] trim_t;
   typedef logic [15:0] sample_t;
endpackage : adc_ctrl_pkg

/* File: src/adc_ctrl_regs.svh */
// Register map, field positions, reset values and timing counts for the
// converter control block. Assumes a 32-bit AHB-Lite slave decodes haddr[7:0].
//
// Function
// RQ1: Attenuation field 0 none, 1..3 scale input range by two, three, four.
// RQ2: Mid-reference short ties converter input to half the reference.
// RQ3: Offset polarity flip bit inverts converter offset sign for conversions.
// RQ4: Chopping makes hardware alternate offset polarity on successive samples.
// RQ5: Non-zero averaging exponent takes 2^n samples combined into one result.
// RQ6: Regulator bleed-load bit enables constant 20 uA regulator load.
// RQ7: Positive and negative offset trims compensate offset; 0x200 is neutral.
// RQ8: Software calibrates with trims 0x200, short on, both polarities.
// RQ9: Software writes trim 0x200 minus difference, doubled if single-ended.
// RQ10: Software should use sample time 2 or 3, averaging 3 or 4.
// RQ11: Software verifies calibration: shorted result near 0x200.
// RQ12: Software writes equal trims 0x300/0x200/0x100 for common mode levels.
// RQ13: Software replaces 0x200 with common-mode trim when combining steps.
// RQ14: Trims can shift zero-scale or full-scale point, e.g. read 0x000.
// RQ15: Software enables, sets pin function 15, channel, mode, then starts.
// RQ16: Software waits for start bit zero or interrupt before reading.
// RQ17: Any write to irq clear port deasserts the conversion-done interrupt; a cv.done in the same cycle keeps it set.
// RQ18: Start stays 1 while converting, hardware clears and flags; no restart.
// RQ19: Continuous run restarts automatically; result holds the latest value.
// RQ20: Chopping makes each conversion two opposite-sign conversions, summed.
// RQ21: Result stored 16-bit left-aligned, not truncated to 10 bits.
// RQ22: Done interrupt stays asserted as a level until software clears it.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define OFS_CTRL 8'h00
`define OFS_CTRL2 8'h04
`define OFS_OFFP 8'h08
`define OFS_OFFN 8'h0c
`define OFS_SEL 8'h10
`define OFS_CLR 8'h14
`define OFS_RESULT 8'h18

// Control word bits
`define B_EN 0
`define B_START 1
`define B_CONT 2
`define B_SE 3
`define B_CHOP 4
`define B_MUTE 5
`define B_SIGN 6
`define B_IRQ 7

// Second control word fields
`define F_ATTN_LO 0
`define F_BLEED 2
`define F_AVG_LO 4
`define F_SMPL_LO 8

`define TRIM_MID 10'h200
`define SEL_RST 4'h0
`define SAMPLE_NS 64
`define SAMPLE_CYC ((`SAMPLE_NS + 7) / 8)

`endif

/* File: src/adc_offset_ctrl.sv */
// Converter control block: AHB-Lite register file, analog control outputs.
// Assumes a single-slave AHB-Lite bus and a comparator sample on sampleIn.
`include "adc_ctrl_regs.svh"
`timescale 1ns/100ps
module adc_offset_ctrl
   import adc_ctrl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [9:0] sampleIn,
   output logic converterEnable,
   output logic [1:0] inputAttenuation,
   output logic midReferenceShort,
   output logic offsetPolarity,
   output logic regulatorBleedLoad,
   output logic singleEndedSelect,
   output logic [9:0] positiveOffsetTrim,
   output logic [9:0] negativeOffsetTrim,
   output logic [3:0] channelSelect,
   output logic conversionDoneIrq
);
   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rstMeta_q, rstN_q;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_q <= 1'b0;
         rstN_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN_q <= rstMeta_q;
      end
   end

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic en_q, en_d, start_q, start_d, cont_q, cont_d, se_q, se_d;
   logic chop_q, chop_d, mute_q, mute_d, sign_q, sign_d, irq_q, irq_d;
   logic [1:0] attn_q, attn_d;
   logic bleed_q, bleed_d;
   logic [2:0] avg_q, avg_d;
   logic [1:0] smpl_q, smpl_d;
   trim_t offp_q, offp_d, offn_q, offn_d;
   logic [3:0] sel_q, sel_d;
   sample_t result_q, result_d;
   logic wrPend_q, wrPend_d;
   logic [7:0] wrAddr_q, wrAddr_d;
   logic [31:0] rdata_d;
   logic launch_q, launch_d;
   logic pol_q;

   conv_if cv ();

   assign cv.startReq = launch_q;
   assign cv.chop = chop_q;
   assign cv.contRun = cont_q;
   assign cv.avgExp = avg_q;

   conv_sequencer u_seq (
      .clk(clk_sys),
      .rstN(rstN_q),
      .polarityBase(sign_q),
      .sampleIn(sampleIn),
      .cv(cv)
   );

   logic addrPhase;
   assign addrPhase = hsel && hready && htrans[1];

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      en_d = en_q;
      start_d = start_q;
      cont_d = cont_q;
      se_d = se_q;
      chop_d = chop_q;
      mute_d = mute_q;
      sign_d = sign_q;
      irq_d = irq_q;
      attn_d = attn_q;
      bleed_d = bleed_q;
      avg_d = avg_q;
      smpl_d = smpl_q;
      offp_d = offp_q;
      offn_d = offn_q;
      sel_d = sel_q;
      result_d = result_q;
      launch_d = 1'b0;
      wrPend_d = addrPhase && hwrite;
      wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
      rdata_d = 32'h00000000;
      if (wrPend_q) begin
         case (wrAddr_q)
            `OFS_CTRL: begin
               en_d = hwdata[`B_EN];
               cont_d = hwdata[`B_CONT];
               se_d = hwdata[`B_SE];
               chop_d = hwdata[`B_CHOP];
               mute_d = hwdata[`B_MUTE]; // RQ2
               sign_d = hwdata[`B_SIGN]; // RQ3
               // Writing 1 while busy is ignored
               if (hwdata[`B_START] && !start_q && hwdata[`B_EN]) begin
                  start_d = 1'b1; // RQ18
                  launch_d = 1'b1;
               end
            end
            `OFS_CTRL2: begin
               attn_d = hwdata[`F_ATTN_LO +: 2]; // RQ1
               bleed_d = hwdata[`F_BLEED]; // RQ6
               avg_d = hwdata[`F_AVG_LO +: 3]; // RQ5
               smpl_d = hwdata[`F_SMPL_LO +: 2];
            end
            `OFS_OFFP: offp_d = hwdata[9:0]; // RQ7 RQ14
            `OFS_OFFN: offn_d = hwdata[9:0]; // RQ7 RQ14
            `OFS_SEL: sel_d = hwdata[3:0];
            `OFS_CLR: irq_d = 1'b0; // RQ17
            default: ;
         endcase
      end
      if (cv.done) begin
         result_d = cv.result; // RQ19 RQ21
         irq_d = 1'b1; // RQ22
         // Continuous run restarts; dropping cont lets start fall
         if (cont_q && en_q) begin
            launch_d = 1'b1; // RQ19
         end else begin
            start_d = 1'b0; // RQ18
         end
      end
      if (addrPhase && !hwrite) begin
         case (haddr[7:0])
            `OFS_CTRL: rdata_d = {24'h000000, irq_q, sign_q, mute_q, chop_q,
               se_q, cont_q, start_q, en_q};
            `OFS_CTRL2: rdata_d = {22'h0, smpl_q, 1'b0, avg_q, 1'b0,
               bleed_q, attn_q};
            `OFS_OFFP: rdata_d = {22'h0, offp_q};
            `OFS_OFFN: rdata_d = {22'h0, offn_q};
            `OFS_SEL: rdata_d = {28'h0000000, sel_q};
            `OFS_RESULT: rdata_d = {16'h0000, result_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         en_q <= 1'b0;
         start_q <= 1'b0;
         cont_q <= 1'b0;
         se_q <= 1'b0;
         chop_q <= 1'b0;
         mute_q <= 1'b0;
         sign_q <= 1'b0;
         irq_q <= 1'b0;
         attn_q <= 2'h0;
         bleed_q <= 1'b0;
         avg_q <= 3'h0;
         smpl_q <= 2'h0;
         offp_q <= `TRIM_MID;
         offn_q <= `TRIM_MID;
         sel_q <= `SEL_RST;
         result_q <= 16'h0000;
         launch_q <= 1'b0;
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         hrdata <= 32'h00000000;
         pol_q <= 1'b0;
      end else begin
         en_q <= en_d;
         start_q <= start_d;
         cont_q <= cont_d;
         se_q <= se_d;
         chop_q <= chop_d;
         mute_q <= mute_d;
         sign_q <= sign_d;
         irq_q <= irq_d;
         attn_q <= attn_d;
         bleed_q <= bleed_d;
         avg_q <= avg_d;
         smpl_q <= smpl_d;
         offp_q <= offp_d;
         offn_q <= offn_d;
         sel_q <= sel_d;
         result_q <= result_d;
         launch_q <= launch_d;
         wrPend_q <= wrPend_d;
         wrAddr_q <= wrAddr_d;
         hrdata <= rdata_d;
         pol_q <= cv.polarity; // RQ4
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Zero-wait slave: every transfer completes in one data-phase cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign converterEnable = en_q;
   assign inputAttenuation = attn_q; // RQ1
   assign midReferenceShort = mute_q; // RQ2
   assign offsetPolarity = pol_q; // RQ3
   assign regulatorBleedLoad = bleed_q; // RQ6
   assign singleEndedSelect = se_q;
   assign positiveOffsetTrim = offp_q; // RQ7
   assign negativeOffsetTrim = offn_q; // RQ7
   assign channelSelect = sel_q;
   assign conversionDoneIrq = irq_q; // RQ22

   a_done_sets_irq: assert property (@(posedge clk_sys) disable iff (!rstN_q)
      cv.done |=> conversionDoneIrq)
      else $error("done did not raise interrupt"); // RQ22
   a_clear_drops_irq: assert property (@(posedge clk_sys)
      disable iff (!rstN_q)
      (wrPend_q && wrAddr_q == `OFS_CLR && !cv.done) |=> !conversionDoneIrq)
      else $error("clear did not drop interrupt"); // RQ17
   a_irq_holds: assert property (@(posedge clk_sys) disable iff (!rstN_q)
      (irq_q && !(wrPend_q && wrAddr_q == `OFS_CLR)) |=> irq_q)
      else $error("interrupt fell without clear"); // RQ22
   a_busy_start_high: assert property (@(posedge clk_sys)
      disable iff (!rstN_q)
      cv.busy |-> start_q)
      else $error("start low during conversion"); // RQ18
   a_no_restart: assert property (@(posedge clk_sys) disable iff (!rstN_q)
      (cv.busy && !cv.done) |-> !launch_d)
      else $error("restart during conversion"); // RQ18
   a_result_latest: assert property (@(posedge clk_sys) disable iff (!rstN_q)
      cv.done |=> result_q == $past(cv.result))
      else $error("result not stored"); // RQ21
   // Relaunch pulse, then the sequencer is busy again
   sequence s_relaunch;
      launch_q ##1 cv.busy;
   endsequence : s_relaunch
   a_cont_relaunch: assert property (@(posedge clk_sys)
      disable iff (!rstN_q)
      (cv.done && cont_q && en_q) |=> s_relaunch)
      else $error("continuous run did not restart"); // RQ19
   a_manual_stop: assert property (@(posedge clk_sys) disable iff (!rstN_q)
      (cv.done && !cont_q) |=> !start_q)
      else $error("start not cleared at completion"); // RQ18
   a_attn_follow: assert property (@(posedge clk_sys) disable iff (!rstN_q)
      (wrPend_q && wrAddr_q == `OFS_CTRL2) |=>
      inputAttenuation == $past(hwdata[1:0]))
      else $error("attenuation not applied"); // RQ1
endmodule : adc_offset_ctrl

/* File: src/conv_if.sv */
// Link between the register file and the conversion sequencer.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface conv_if;
   logic startReq;
   logic chop;
   logic contRun;
   logic [2:0] avgExp;
   logic busy;
   logic done;
   logic polarity;
   logic [15:0] result;
   modport ctrl (output startReq, chop, contRun, avgExp,
      input busy, done, polarity, result);
   modport seq (input startReq, chop, contRun, avgExp,
      output busy, done, polarity, result);
endinterface : conv_if

/* File: src/conv_sequencer.sv */
// Conversion sequencer: sample count, chopping, averaging, accumulation.
// Assumes one 10-bit comparator sample is ready after SAMPLE_CYC clocks.
`include "adc_ctrl_regs.svh"
`timescale 1ns/100ps
module conv_sequencer
   import adc_ctrl_pkg::*;
(
   input wire logic clk,
   input wire logic rstN,
   input wire logic polarityBase,
   input wire logic [9:0] sampleIn,
   conv_if.seq cv
);
   localparam int SMPL_CYC = `SAMPLE_CYC;

   seq_state_t state_q, state_d;
   logic [7:0] cnt_q, cnt_d;
   logic [8:0] nLeft_q, nLeft_d;
   logic [19:0] acc_q, acc_d;
   logic flip_q, flip_d;
   logic done_d;
   logic [15:0] res_q, res_d;

   // Normalises 2^n (doubled for chop) sums back to a left-aligned word
   function automatic logic [15:0] alignSum(input logic [19:0] s,
         input logic [2:0] e, input logic ch);
      logic [4:0] sh;
      logic [35:0] w;
      sh = 5'(e) + 5'(ch);
      w = {s, 16'h0000} >> sh;
      alignSum = w[25:10];
   endfunction : alignSum

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      nLeft_d = nLeft_q;
      acc_d = acc_q;
      flip_d = flip_q;
      done_d = 1'b0;
      res_d = res_q;
      case (state_q)
         SEQ_IDLE: begin
            if (cv.startReq) begin
               state_d = SEQ_SAMPLE;
               cnt_d = 8'(SMPL_CYC - 1);
               // Chop forces at least two samples
               nLeft_d = (9'h001 << cv.avgExp) << cv.chop; // RQ5 RQ20
               acc_d = 20'h00000;
               flip_d = 1'b0;
            end
         end
         SEQ_SAMPLE: begin
            if (cnt_q != 8'h00) begin
               cnt_d = cnt_q - 8'h01;
            end else begin
               acc_d = acc_q + 20'(sampleIn); // RQ20
               nLeft_d = nLeft_q - 9'h001;
               flip_d = cv.chop ? ~flip_q : flip_q; // RQ4
               cnt_d = 8'(SMPL_CYC - 1);
               if (nLeft_q == 9'h001) begin
                  state_d = SEQ_DONE;
               end
            end
         end
         SEQ_DONE: begin
            res_d = alignSum(acc_q, cv.avgExp, cv.chop); // RQ21
            done_d = 1'b1;
            state_d = SEQ_IDLE;
         end
         default: state_d = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_q <= SEQ_IDLE;
         cnt_q <= 8'h00;
         nLeft_q <= 9'h000;
         acc_q <= 20'h00000;
         flip_q <= 1'b0;
         cv.done <= 1'b0;
         res_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         nLeft_q <= nLeft_d;
         acc_q <= acc_d;
         flip_q <= flip_d;
         cv.done <= done_d;
         res_q <= res_d;
      end
   end

   assign cv.busy = (state_q != SEQ_IDLE);
   assign cv.polarity = polarityBase ^ flip_q; // RQ3 RQ4
   assign cv.result = res_q;

   a_chop_alternates: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == SEQ_SAMPLE && cnt_q == 8'h00 && cv.chop
       && nLeft_q != 9'h001) |=> cv.polarity != $past(cv.polarity))
      else $error("chop polarity did not alternate"); // RQ4
   a_done_one_pulse: assert property (@(posedge clk) disable iff (!rstN)
      cv.done |=> !cv.done)
      else $error("done pulse longer than one cycle"); // RQ18
endmodule : conv_sequencer

/* File: test/adc_offset_ctrl_tb.sv */
// Register-level bench for the converter control block.
// Assumes the front-end model below and a single-slave AHB-Lite bus.
`include "adc_ctrl_regs.svh"
`timescale 1ns/100ps
module adc_offset_ctrl_tb;
   import adc_ctrl_pkg::*;
   localparam logic [9:0] OFS = 10'h01c;
   logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [9:0] sampleIn, testLevel, posTrim, negTrim;
   logic [1:0] inputAttenuation;
   logic [3:0] channelSelect;
   logic converterEnable, midReferenceShort, offsetPolarity;
   logic regulatorBleedLoad, singleEndedSelect, conversionDoneIrq;
   int miscompares = 0;
   int checkCount = 0;
   logic [31:0] res, res2;
   adc_offset_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .sampleIn(sampleIn),
      .converterEnable(converterEnable),
      .inputAttenuation(inputAttenuation),
      .midReferenceShort(midReferenceShort),
      .offsetPolarity(offsetPolarity),
      .regulatorBleedLoad(regulatorBleedLoad),
      .singleEndedSelect(singleEndedSelect),
      .positiveOffsetTrim(posTrim), .negativeOffsetTrim(negTrim),
      .channelSelect(channelSelect), .conversionDoneIrq(conversionDoneIrq));
   analog_front_model #(.OFFSET(OFS)) front (
      .midReferenceShort(midReferenceShort),
      .offsetPolarity(offsetPolarity), .positiveOffsetTrim(posTrim),
      .negativeOffsetTrim(negTrim), .testLevel(testLevel),
      .sampleIn(sampleIn));
   // ***************************************************
   // Helpers
   // ***************************************************
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checkCount++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // A bus wait ends at the first edge with hreadyout high; only the watchdog ends a stuck one
   task automatic waitReady();
      do begin
         @(posedge clk_sys);
      end while (hreadyout !== 1'b1);
   endtask : waitReady
   // Outputs are read at an edge, before that edge's updates land
   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
   endtask : step
   task automatic ahbWrite(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      htrans <= 2'b10;
      waitReady();
      htrans <= 2'b00;
      hwdata <= d;
      waitReady();
   endtask : ahbWrite
   task automatic ahbRead(input logic [7:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      htrans <= 2'b10;
      waitReady();
      htrans <= 2'b00;
      waitReady();
      d = hrdata;
   endtask : ahbRead
   task automatic waitIdle(output logic [31:0] rd);
      int n;
      n = 0;
      do begin
         ahbRead(`OFS_CTRL, rd);
         n++;
      end while (rd[`B_START] !== 1'b0 && n < 400);
      check(32'(rd[`B_START]), 32'h0);
   endtask : waitIdle
   task automatic convert(input logic [31:0] mode, output logic [31:0] r);
      logic [31:0] rd;
      ahbWrite(`OFS_CTRL, mode | 32'h3);
      ahbRead(`OFS_CTRL, rd);
      check(32'(rd[`B_START]), 32'h1);
      waitIdle(rd);
      check(32'(rd[`B_IRQ]), 32'h1);
      ahbWrite(`OFS_CLR, 32'h0000_005a);
      step(1);
      check(32'(conversionDoneIrq), 32'h0);
      ahbRead(`OFS_RESULT, r);
   endtask : convert
   task automatic endOfTest();
      $display("compares %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : endOfTest
   initial begin
      repeat (30000) @(posedge clk_sys);
      miscompares++;
      endOfTest();
   end
   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      testLevel = 10'h155;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      step(3);
      ahbRead(`OFS_OFFP, res);
      check(res, 32'h200);
      ahbRead(`OFS_OFFN, res);
      check(res, 32'h200);
      ahbRead(8'h1c, res);
      check(res, 32'h0);
      check(32'(hresp), 32'h0);
      for (int i = 0; i < 4; i++) begin
         ahbWrite(`OFS_CTRL2, 32'(i) | (32'(i % 2) << `F_BLEED));
         step(1);
         check(32'(inputAttenuation), 32'(i));
         check(32'(regulatorBleedLoad), 32'(i % 2));
      end
      ahbWrite(`OFS_SEL, 32'h9);
      ahbWrite(`OFS_CTRL, 32'h29);
      step(1);
      check(32'({channelSelect, singleEndedSelect, midReferenceShort,
         converterEnable}), 32'h4f);
      // Offset calibration in differential mode
      ahbWrite(`OFS_CTRL2,
         (32'h2 << `F_SMPL_LO) | (32'h3 << `F_AVG_LO));
      convert(32'h20, res);
      check(res, 32'(10'h200 + OFS) << 6);
      convert(32'h60, res2);
      check(32'(offsetPolarity), 32'h1);
      check(res2, 32'(10'h200 - OFS) << 6);
      ahbWrite(`OFS_OFFP, 32'h200 - ((res >> 6) - 32'h200));
      ahbWrite(`OFS_OFFN, 32'h200 - ((res2 >> 6) - 32'h200));
      step(1);
      check(32'(posTrim), 32'(10'h200 - OFS));
      check(32'(negTrim), 32'(10'h200 + OFS));
      convert(32'h20, res);
      check(res, 32'h8000);
      convert(32'h60, res);
      check(res, 32'h8000);
      ahbWrite(`OFS_CTRL2, 32'h2 << `F_AVG_LO);
      convert(32'h0, res);
      check(res, 32'h155 << 6);
      // Chopping cancels an uncalibrated offset
      ahbWrite(`OFS_OFFP, 32'h200);
      ahbWrite(`OFS_OFFN, 32'h200);
      convert(32'h30, res);
      check(res, 32'h8000);
      // A second start during a conversion is ignored
      ahbWrite(`OFS_CTRL, 32'h3);
      ahbWrite(`OFS_CTRL, 32'h3);
      waitIdle(res);
      ahbWrite(`OFS_CLR, 32'h0);
      step(300);
      check(32'(conversionDoneIrq), 32'h0);
      // Continuous run keeps the flag and the latest value
      testLevel <= 10'h0aa;
      ahbWrite(`OFS_CTRL, 32'h7);
      step(60);
      check(32'(conversionDoneIrq), 32'h1);
      testLevel <= 10'h0f0;
      step(150);
      check(32'(conversionDoneIrq), 32'h1);
      ahbRead(`OFS_RESULT, res);
      check(res, (32'h0f0 + 32'(OFS)) << 6);
      ahbWrite(`OFS_CTRL, 32'h1);
      waitIdle(res);
      check(res & 32'h6, 32'h0);
      // Reset with the converter idle drops the flag and restores the negative trim
      ahbWrite(`OFS_OFFN, 32'h155);
      arst_n <= 1'b0;
      step(2);
      check(32'(conversionDoneIrq), 32'h0);
      check(32'(negTrim), 32'h200);
      arst_n <= 1'b1;
      step(3);
      ahbRead(`OFS_CTRL, res);
      check(res, 32'h0);
      endOfTest();
   end
endmodule : adc_offset_ctrl_tb

/* File: test/analog_front_model.sv */
// Behavioural analog sampling network and comparator for the bench.
// Assumes the control outputs of the block are settled between samples.
`timescale 1ns/100ps
module analog_front_model #(
   parameter logic [9:0] OFFSET = 10'h01c
) (
   input wire logic midReferenceShort,
   input wire logic offsetPolarity,
   input wire logic [9:0] positiveOffsetTrim,
   input wire logic [9:0] negativeOffsetTrim,
   input wire logic [9:0] testLevel,
   output logic [9:0] sampleIn
);
   logic [9:0] base;
   // Comparator offset flips with polarity; each trim acts on its own sign
   always_comb begin
      base = midReferenceShort ? 10'h200 : testLevel;
      if (offsetPolarity) begin
         sampleIn = base - OFFSET + (negativeOffsetTrim - 10'h200);
      end else begin
         sampleIn = base + OFFSET + (positiveOffsetTrim - 10'h200);
      end
   end
endmodule : analog_front_model
